/* core/sadc_pkg.sv */
// Constants and types shared by the converter control block
package sadc_pkg;

  // ****************************************************************
  // Register map: printed indices, byte address is four times each
  // ****************************************************************
  localparam logic [7:0] CSR_INDEX = 8'h45;
  localparam logic [7:0] UPPER_INDEX = 8'h46;
  localparam logic [7:0] LOWER_INDEX = 8'h47;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] CSR_ADDR = {2'h0, CSR_INDEX, 2'h0};
  localparam logic [11:0] UPPER_ADDR = {2'h0, UPPER_INDEX, 2'h0};
  localparam logic [11:0] LOWER_ADDR = {2'h0, LOWER_INDEX, 2'h0};

  // ****************************************************************
  // Reset values and result codes
  // ****************************************************************
  localparam logic [7:0] CSR_RESET = 8'h00;
  localparam logic [9:0] RESULT_RESET = 10'h000;
  localparam logic [9:0] FULL_SCALE = 10'h3FF;
  localparam logic [9:0] ZERO_SCALE = 10'h000;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;

  // ****************************************************************
  // Converter clock selection, index is {slow, speed}
  // ****************************************************************
  localparam logic [1:0] CLKSEL_DIV2 = 2'h0;
  localparam logic [1:0] CLKSEL_UNDIV = 2'h1;
  localparam logic [1:0] CLKSEL_DIV4 = 2'h2;
  localparam logic [1:0] CLKSEL_DIV2_ALT = 2'h3;
  localparam logic [1:0] DIV1_LAST = 2'h0;
  localparam logic [1:0] DIV2_LAST = 2'h1;
  localparam logic [1:0] DIV4_LAST = 2'h3;
  // Highest CPU clock at which the undivided setting is allowed
  localparam int unsigned UNDIV_MAX_HZ = 4_000_000;

  // Default conversion length in converter-clock ticks
  localparam int unsigned CONV_TICKS_DEFAULT = 14;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic eoc;
    logic speed;
    logic power_on;
    logic slow;
    logic [3:0] input_select;
  } sadc_csr_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
  } sadc_bus_req_t;

  typedef enum logic [0:0] {
    SADC_OFF = 1'b0,
    SADC_RUN = 1'b1
  } sadc_state_t;

endpackage : sadc_pkg

/* core/sadc_ctrl.sv */
// Control, clocking and result logic of the 10-bit converter
//
// How it works
// (R1) Input above high reference reads full scale: upper FFh, lower 03h.
// (R2) Input below low reference reads zero in both result registers.
// (R3) Setting power-on starts conversions, repeated without software help.
// (R4) Each completed conversion sets the done flag; it loads the result unless locked or a lower read is under way.
// (R5) Reading the upper result register clears the done flag.
// (R6) Any write to the control/status register clears the done flag.
// (R7) Channel change mid-conversion aborts, clears done, restarts new channel.
// (R8) Reading the lower result register locks both result registers.
// (R9) Reading upper result or clearing power-on unlocks the results.
// (R10) While locked, finished results are dropped until the upper read.
// (R11) Clock pair {slow,speed}: 00 /2, 01 /1, 10 /4, 11 /2.
// (R12) Clearing power-on disables the converter and stops conversion.
// (R13) Four-bit input select picks analog input 0 to 15.
// (R14) Upper result register shows result bits 9:2 in bits 7:0.
// (R15) Lower register shows result bits 1:0; bits 7:2 read zero.
// (R16) Done flag bit 7 is read-only; results are read-only.
// (R17) All three registers reset to zero.
// (R18) CPU wait mode does not affect the converter.
// (R19) Halt mode disables the converter; software waits to settle.
// (R20) Software polls done, reads lower, then upper for ten bits.
// (R21) Software polls done, then reads only upper for eight bits.
// (R22) Conversion length in ticks is a parameter, same every time.
`timescale 1ns/100ps
`default_nettype none

module sadc_ctrl #(
  parameter int unsigned CONV_TICKS = sadc_pkg::CONV_TICKS_DEFAULT
) (
  input wire logic CLK_SYS_IN,
  input wire logic SRST_IN,
  input wire logic CE_IN,
  input wire logic HSEL_IN,
  input wire logic [31:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  input wire logic HALT_IN,
  input wire logic [9:0] SAMPLE_CODE_IN,
  input wire logic ABOVE_HIGH_IN,
  input wire logic BELOW_LOW_IN,
  output logic CONV_POWER_OUT,
  output logic CONV_START_OUT,
  output logic CONV_CLK_EN_OUT,
  output logic [3:0] INPUT_SELECT_OUT
);

  // ****************************************************************
  // State
  // ****************************************************************
  sadc_pkg::sadc_csr_t csr_q;
  sadc_pkg::sadc_csr_t csr_d;
  sadc_pkg::sadc_state_t state_q;
  sadc_pkg::sadc_state_t state_d;
  sadc_pkg::sadc_bus_req_t req_q;
  logic [9:0] result_q;
  logic locked_q;
  logic locked_d;
  logic [1:0] div_q;
  logic tick_q;
  logic [7:0] tick_cnt_q;
  logic start_q;
  logic power_q;
  logic [31:0] hrdata_q;
  logic hready_q;

  localparam logic [7:0] TICK_LAST = 8'(CONV_TICKS - 1);

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire take = CE_IN && HSEL_IN && HREADY_IN && HTRANS_IN[1];
  wire data_ph = CE_IN && req_q.valid;
  wire hit_csr = req_q.addr == sadc_pkg::CSR_ADDR;
  wire hit_upper = req_q.addr == sadc_pkg::UPPER_ADDR;
  wire hit_lower = req_q.addr == sadc_pkg::LOWER_ADDR;
  wire wr_csr = data_ph && req_q.write && hit_csr;
  wire rd_upper = data_ph && !req_q.write && hit_upper;
  wire rd_lower = data_ph && !req_q.write && hit_lower;
  wire [7:0] wr_byte = HWDATA_IN[7:0];

  // ****************************************************************
  // Converter sequencing
  // ****************************************************************
  wire running = state_q == sadc_pkg::SADC_RUN;
  // Wait mode has no input: only halt gates the converter besides power-on
  wire run_next = csr_d.power_on && !HALT_IN; // R18 R19
  wire [1:0] clk_sel = {csr_q.slow, csr_q.speed};
  wire chan_change = wr_csr && running && run_next
    && (wr_byte[3:0] != csr_q.input_select); // R7
  wire abort = running && (!run_next || chan_change); // R12
  wire conv_done = CE_IN && running && !abort && tick_q
    && (tick_cnt_q == TICK_LAST); // R22
  // A finished conversion immediately begins the next one
  wire start = CE_IN && run_next
    && (!running || chan_change || conv_done); // R3
  wire [9:0] clamped_code = ABOVE_HIGH_IN ? sadc_pkg::FULL_SCALE // R1
    : BELOW_LOW_IN ? sadc_pkg::ZERO_SCALE // R2
    : SAMPLE_CODE_IN;
  // A lower read in the same cycle keeps the pair it is reading together
  wire load_result = conv_done && !locked_q && !rd_lower; // R8 R10
  wire [1:0] div_last = (clk_sel == sadc_pkg::CLKSEL_UNDIV)
    ? sadc_pkg::DIV1_LAST // R11
    : (clk_sel == sadc_pkg::CLKSEL_DIV4) ? sadc_pkg::DIV4_LAST
    : sadc_pkg::DIV2_LAST;
  wire eoc_clear = wr_csr || rd_upper; // R5

  // ****************************************************************
  // Read data selection
  // ****************************************************************
  wire [31:0] rd_csr_word = {24'h00_0000, csr_q};
  wire [31:0] rd_upper_word = {24'h00_0000, result_q[9:2]}; // R14
  wire [31:0] rd_lower_word = {30'h0000_0000, result_q[1:0]}; // R15
  wire [31:0] rd_word = hit_csr ? rd_csr_word
    : hit_upper ? rd_upper_word
    : hit_lower ? rd_lower_word
    : sadc_pkg::READ_ZERO;

  // Hardware set wins over any clear landing in the same cycle
  always_comb
  begin
    csr_d = csr_q;
    if (wr_csr)
    begin
      csr_d.speed = wr_byte[6]; // R16
      csr_d.power_on = wr_byte[5];
      csr_d.slow = wr_byte[4];
      csr_d.input_select = wr_byte[3:0];
    end
    if (conv_done)
    begin
      csr_d.eoc = 1'b1; // R4
    end
    else if (eoc_clear || chan_change)
    begin
      csr_d.eoc = 1'b0; // R6
    end
  end

  // Unlock has priority so a converter with power-on cleared never stays locked
  always_comb
  begin
    locked_d = locked_q;
    if (rd_upper || !csr_d.power_on)
    begin
      locked_d = 1'b0; // R9
    end
    else if (rd_lower)
    begin
      locked_d = 1'b1; // R8
    end
  end

  always_comb
  begin
    state_d = state_q;
    if (CE_IN)
    begin
      case (state_q)
        sadc_pkg::SADC_OFF:
          state_d = run_next ? sadc_pkg::SADC_RUN : sadc_pkg::SADC_OFF;
        sadc_pkg::SADC_RUN:
          state_d = run_next ? sadc_pkg::SADC_RUN : sadc_pkg::SADC_OFF;
        default:
          state_d = sadc_pkg::SADC_OFF;
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (SRST_IN)
    begin
      csr_q <= sadc_pkg::CSR_RESET; // R17
      locked_q <= 1'b0;
      state_q <= sadc_pkg::SADC_OFF;
    end
    else if (CE_IN)
    begin
      csr_q <= csr_d;
      locked_q <= locked_d;
      state_q <= state_d;
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (SRST_IN)
    begin
      result_q <= sadc_pkg::RESULT_RESET; // R17
    end
    else if (load_result)
    begin
      result_q <= clamped_code; // R4
    end
  end

  // Divider restarts with every conversion so each one has equal length
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (SRST_IN)
    begin
      div_q <= 2'h0;
      tick_q <= 1'b0;
    end
    else if (CE_IN)
    begin
      if (start || !running)
      begin
        div_q <= 2'h0;
        tick_q <= 1'b0;
      end
      else if (div_q >= div_last)
      begin
        div_q <= 2'h0;
        tick_q <= 1'b1; // R11
      end
      else
      begin
        div_q <= div_q + 2'h1;
        tick_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (SRST_IN)
    begin
      tick_cnt_q <= 8'h00;
    end
    else if (CE_IN)
    begin
      if (start || !running)
      begin
        tick_cnt_q <= 8'h00; // R7
      end
      else if (tick_q)
      begin
        tick_cnt_q <= tick_cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge CLK_SYS_IN)
  begin
    if (SRST_IN)
    begin
      start_q <= 1'b0;
      power_q <= 1'b0;
    end
    else if (CE_IN)
    begin
      start_q <= start; // R3
      power_q <= run_next; // R12
    end
  end

  // ****************************************************************
  // AHB-Lite slave: one wait state, response always OKAY
  // ****************************************************************
  always_ff @(posedge CLK_SYS_IN)
  begin
    if (SRST_IN)
    begin
      req_q <= '0;
      hready_q <= 1'b1;
      hrdata_q <= sadc_pkg::READ_ZERO;
    end
    else if (CE_IN)
    begin
      req_q.valid <= take;
      req_q.write <= HWRITE_IN;
      req_q.addr <= HADDR_IN[sadc_pkg::ADDR_W-1:0];
      hready_q <= !take;
      if (data_ph && !req_q.write)
      begin
        hrdata_q <= rd_word;
      end
    end
  end

  assign HRDATA_OUT = hrdata_q;
  assign HREADYOUT_OUT = hready_q;
  assign HRESP_OUT = 1'b0;
  assign CONV_POWER_OUT = power_q;
  assign CONV_START_OUT = start_q;
  assign CONV_CLK_EN_OUT = tick_q;
  assign INPUT_SELECT_OUT = csr_q.input_select; // R13

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_SYS_IN);
  endclocking
  default disable iff (SRST_IN);

  a_full_scale_clamp: assert property ( // R1
    load_result && ABOVE_HIGH_IN |=> result_q == 10'h3FF
  ) else $error("over-range input not clamped to full scale");

  a_zero_clamp: assert property ( // R2
    load_result && BELOW_LOW_IN && !ABOVE_HIGH_IN |=> result_q == 10'h000
  ) else $error("under-range input not clamped to zero");

  a_power_starts: assert property ( // R3
    CE_IN && !running && run_next |=> CONV_START_OUT && CONV_POWER_OUT
  ) else $error("power-on did not start a conversion");

  a_done_sets_flag: assert property ( // R4
    conv_done |=> csr_q.eoc && tick_cnt_q == 8'h00
  ) else $error("finished conversion did not set done flag");

  a_upper_read_clear: assert property ( // R5
    rd_upper && !conv_done |=> !csr_q.eoc && !locked_q
  ) else $error("upper read did not clear done flag and lock");

  a_write_clear: assert property ( // R6
    wr_csr && !conv_done |=> !csr_q.eoc
  ) else $error("control write did not clear done flag");

  a_chan_restart: assert property ( // R7
    chan_change |=> CONV_START_OUT && !csr_q.eoc && tick_cnt_q == 8'h00
  ) else $error("channel change did not restart conversion");

  a_lower_locks: assert property ( // R8
    rd_lower && csr_q.power_on |=> locked_q
  ) else $error("lower read did not lock results");

  a_locked_stable: assert property ( // R10
    locked_q |=> $stable(result_q)
  ) else $error("locked result registers changed");

  a_off_stops: assert property ( // R12
    CE_IN && !run_next |=> !CONV_POWER_OUT && !CONV_START_OUT
  ) else $error("converter still active after power-off");

  a_upper_view: assert property ( // R14
    rd_upper |=> HRDATA_OUT == {24'h00_0000, $past(result_q[9:2])}
  ) else $error("upper result read data wrong");

  a_lower_view: assert property ( // R15
    rd_lower |=> HRDATA_OUT[31:2] == 30'h0000_0000
  ) else $error("lower result reserved bits not zero");

  a_lower_read_hold: assert property ( // R8
    rd_lower |=> $stable(result_q)
  ) else $error("result changed under a lower read");

  a_write_fields: assert property ( // R16
    wr_csr |=> csr_q[6:0] == $past(HWDATA_IN[6:0])
  ) else $error("control write fields not stored");

  a_halt_off: assert property ( // R19
    CE_IN && HALT_IN |=> !CONV_POWER_OUT && !running
  ) else $error("converter active during halt");

  c_conv_done: cover property (conv_done);
  c_chan_change: cover property (chan_change);
  c_locked_drop: cover property (rd_lower ##[1:100] (conv_done && locked_q));
  c_halt_stop: cover property (running && HALT_IN ##1 !CONV_POWER_OUT);

endmodule : sadc_ctrl

`default_nettype wire

/* bench/sadc_analog_model.sv */
// Behavioural model of the multiplexed analog inputs and sampling core
`timescale 1ns/100ps
`default_nettype none
module sadc_analog_model (
  input wire logic [3:0] sel_in,
  input wire logic power_in,
  input wire logic [5:0] level_in,
  input wire logic [1:0] range_in,
  output logic [9:0] code_out,
  output logic above_out,
  output logic below_out
);
  // Code names the selected input so a wrong channel shows up in the result
  // An unpowered core gives an inverted code, never the last good one
  assign code_out = power_in ? {sel_in, level_in} : ~{sel_in, level_in};
  assign above_out = (range_in == 2'h1);
  assign below_out = (range_in == 2'h2);
endmodule : sadc_analog_model
`default_nettype wire

/* bench/tb_top.sv */
// Self-checking bench of the converter control block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  localparam int unsigned TICKS = 16;
  localparam int CS = 0, UP = 1, LO = 2, NA = 3;
  localparam logic [11:0] AD [4] = '{sadc_pkg::CSR_ADDR,
    sadc_pkg::UPPER_ADDR, sadc_pkg::LOWER_ADDR, 12'h200};
  localparam int DIVS [4] = '{2, 1, 4, 2};
  typedef struct packed {logic chk; logic [31:0] val;} sadc_exp_t;
  logic clk = 1'b0, srst = 1'b1, hsel = 1'b0, hwrite = 1'b0, halt = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0, range = 2'h0;
  logic [5:0] level = 6'h00;
  logic hready, hresp, pwr, start, tick, above, below, rd_dp = 1'b0;
  logic [9:0] code;
  logic [3:0] sel;
  sadc_exp_t exp_q[$];
  int err_total = 0, n_compared = 0, cycles = 0, seed = 57182;
  int n, t0, last_start = 0, n_ticks = 0;

  always #5 clk = ~clk;

  sadc_ctrl #(.CONV_TICKS(TICKS)) i_dut (.CLK_SYS_IN(clk), .SRST_IN(srst),
    .CE_IN(1'b1), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
    .HWRITE_IN(hwrite), .HWDATA_IN(hwdata), .HREADY_IN(hready),
    .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp),
    .HALT_IN(halt), .SAMPLE_CODE_IN(code), .ABOVE_HIGH_IN(above),
    .BELOW_LOW_IN(below), .CONV_POWER_OUT(pwr), .CONV_START_OUT(start),
    .CONV_CLK_EN_OUT(tick), .INPUT_SELECT_OUT(sel));
  sadc_analog_model i_ana (.sel_in(sel), .power_in(pwr), .level_in(level),
    .range_in(range), .code_out(code), .above_out(above), .below_out(below));

  // ****************************************************************
  // Checking, bus and timing tasks
  // ****************************************************************
  task automatic check(input string name, input logic [31:0] ev,
    input logic [31:0] got);
    n_compared++;
    if (got !== ev)
    begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", name, ev, got);
    end
  endtask : check

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  // Hang guard, latest conversion start, and ticks counted since it
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (start === 1'b1)
    begin
      last_start <= cycles;
      n_ticks <= 0;
    end
    else if (tick === 1'b1)
      n_ticks <= n_ticks + 1;
    if (cycles == 10000)
    begin
      err_total++;
      finish_test();
    end
  end

  // Read results are compared against the oldest note as they complete
  always @(posedge clk)
  begin
    sadc_exp_t e;
    if (rd_dp && hready === 1'b1 && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      if (e.chk)
        check("read data", e.val, hrdata);
      check("response", 32'h0, {31'h0, hresp});
    end
    rd_dp <= (hsel & htrans[1] & hready & ~hwrite) | (rd_dp & ~hready);
  end

  task automatic bus(input logic wr, input logic [11:0] a,
    input logic [7:0] wd, input logic chk, input logic [31:0] ev);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, a};
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    if (!wr)
      exp_q.push_back('{chk, ev});
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic rd_chk(input int i, input logic [31:0] ev);
    bus(1'b0, AD[i], 8'h00, 1'b1, ev);
  endtask : rd_chk

  task automatic wr(input int i, input logic [7:0] d);
    bus(1'b1, AD[i], d, 1'b0, 32'h0);
  endtask : wr

  task automatic poll;
    do bus(1'b0, AD[CS], 8'h00, 1'b0, 32'h0); while (rd[7] !== 1'b1);
  endtask : poll

  task automatic result(input logic [9:0] v, input bit ten);
    if (ten)
      rd_chk(LO, {30'h0, v[1:0]});
    rd_chk(UP, {24'h0, v[9:2]});
  endtask : result

  task automatic wait_start(output int cnt);
    cnt = 0;
    do
    begin
      @(posedge clk);
      cnt++;
    end
    while (start !== 1'b1);
  endtask : wait_start

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd_chk(CS, 32'h0);
    rd_chk(UP, 32'h0);
    rd_chk(LO, 32'h0);
    wr(CS, 8'hDF);
    wr(UP, 8'hAA);
    wr(NA, 8'hFF);
    rd_chk(CS, 32'h5F);
    rd_chk(UP, 32'h0);
    rd_chk(NA, 32'h0);
    check("power", 32'h0, {31'h0, pwr});
    $display("Test registers done");
    // Bench clock stands for a CPU clock slow enough for the undivided mode
    for (int k = 0; k < 4; k++)
    begin
      wr(CS, {1'b0, k[0], 1'b1, k[1], 4'h3});
      wait_start(n);
      wait_start(n);
      check("period", DIVS[k] * TICKS + 1, n);
      check("ticks", TICKS, n_ticks);
    end
    $display("Test clock selection done");
    for (int ch = 0; ch < 16; ch++)
    begin
      level <= 6'($random(seed));
      wr(CS, {4'h6, 4'(ch)});
      @(posedge clk);
      check("select", 32'(ch), {28'h0, sel});
      poll();
      result({4'(ch), level}, !ch[0]);
      rd_chk(CS, {24'h0, 4'h6, 4'(ch)});
    end
    $display("Test channels done");
    level <= 6'h15;
    wr(CS, 8'h35);
    poll();
    rd_chk(LO, 32'h1);
    level <= 6'h2A;
    repeat (2 * (4 * TICKS + 1) + 4) @(posedge clk);
    rd_chk(UP, 32'h55);
    poll();
    result(10'h16A, 1'b1);
    rd_chk(LO, 32'h2);
    level <= 6'h0F;
    wr(CS, 8'h15);
    t0 = cycles;
    repeat (80) @(posedge clk);
    check("stopped", 32'h0, {31'h0, pwr});
    check("no start", 1, {31'h0, last_start < t0});
    wr(CS, 8'h35);
    poll();
    result(10'h14F, 1'b1);
    $display("Test lock done");
    poll();
    repeat (10) @(posedge clk);
    t0 = cycles;
    wr(CS, 8'h3A);
    repeat (3) @(posedge clk);
    check("restart", 1, {31'h0, last_start > t0});
    rd_chk(CS, 32'h3A);
    poll();
    wr(CS, 8'h3A);
    rd_chk(CS, 32'h3A);
    range <= 2'h1;
    wr(CS, 8'h3A);
    poll();
    result(sadc_pkg::FULL_SCALE, 1'b1);
    range <= 2'h2;
    wr(CS, 8'h3A);
    poll();
    result(sadc_pkg::ZERO_SCALE, 1'b1);
    $display("Test restart and range done");
    range <= 2'h0;
    halt <= 1'b1;
    repeat (3) @(posedge clk);
    check("halted", 32'h0, {31'h0, pwr});
    halt <= 1'b0;
    // Settling time after wakeup before results are trusted
    repeat (8) @(posedge clk);
    wr(CS, 8'h3A);
    poll();
    result(10'h28F, 1'b1);
    $display("Test halt done");
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
